/* File: hdl/timer_encoder_slave.sv */
// encoder interface, input xor and reset / gated slave modes of a timer
// assumes apb3 master on core_clk, pins may be asynchronous and are resynchronised here
`timescale 1ns/1ps
module timer_encoder_slave (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  channelPin,
  output logic             timerIrq,
  output logic             compareHit
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
    isReg = (addr == off);
  endfunction : isReg

  // ****************************************
  // registers
  // ****************************************
  logic                               cen_q, urs_q, dir_q, xorSel_q;
  timer_slave_pkg::slave_cfg_t        slave_q;
  logic [15:0]                        capMode_q;
  logic                               capEn1_q, pol1_q, pol2_q;
  logic [15:0]                        cnt_q, pscCnt_q, pscPre_q, pscAct_q;
  logic [15:0]                        arrPre_q, arrAct_q, ccrPre_q, ccrAct_q;
  logic [6:0]                         flag_q, intCfg_q;
  logic                               pready_q, pslverr_q, irq_q, cmpHit_q;
  logic [31:0]                        prdata_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire setupPh = psel & ~penable;
  wire access  = psel & penable & pready_q;
  wire wrEn    = access & pwrite;
  wire hitAny  = isReg(paddr, timer_slave_pkg::OFF_CTRL1) |
                 isReg(paddr, timer_slave_pkg::OFF_CTRL2) |
                 isReg(paddr, timer_slave_pkg::OFF_SLAVE) |
                 isReg(paddr, timer_slave_pkg::OFF_CAPMODE) |
                 isReg(paddr, timer_slave_pkg::OFF_CAPEN) |
                 isReg(paddr, timer_slave_pkg::OFF_COUNT) |
                 isReg(paddr, timer_slave_pkg::OFF_PRESC) |
                 isReg(paddr, timer_slave_pkg::OFF_RELOAD) |
                 isReg(paddr, timer_slave_pkg::OFF_FLAG) |
                 isReg(paddr, timer_slave_pkg::OFF_INTCFG) |
                 isReg(paddr, timer_slave_pkg::OFF_EVGEN) |
                 isReg(paddr, timer_slave_pkg::OFF_COMPARE);
  wire wrCtrl1 = wrEn & isReg(paddr, timer_slave_pkg::OFF_CTRL1);
  wire wrCtrl2 = wrEn & isReg(paddr, timer_slave_pkg::OFF_CTRL2);
  wire wrSlave = wrEn & isReg(paddr, timer_slave_pkg::OFF_SLAVE);
  wire wrCapMd = wrEn & isReg(paddr, timer_slave_pkg::OFF_CAPMODE);
  wire wrCapEn = wrEn & isReg(paddr, timer_slave_pkg::OFF_CAPEN);
  wire wrCount = wrEn & isReg(paddr, timer_slave_pkg::OFF_COUNT);
  wire wrPresc = wrEn & isReg(paddr, timer_slave_pkg::OFF_PRESC);
  wire wrReld  = wrEn & isReg(paddr, timer_slave_pkg::OFF_RELOAD);
  wire wrFlag  = wrEn & isReg(paddr, timer_slave_pkg::OFF_FLAG);
  wire wrIntCf = wrEn & isReg(paddr, timer_slave_pkg::OFF_INTCFG);
  wire wrEvGen = wrEn & isReg(paddr, timer_slave_pkg::OFF_EVGEN);
  wire wrComp  = wrEn & isReg(paddr, timer_slave_pkg::OFF_COMPARE);

  wire [31:0] ctrl1Rd = {27'h0, dir_q, 1'b0, urs_q, 1'b0, cen_q};
  wire [31:0] capEnRd = {26'h0, pol2_q, 3'h0, pol1_q, capEn1_q};
  wire [31:0] rdMux =
    isReg(paddr, timer_slave_pkg::OFF_CTRL1)   ? ctrl1Rd :
    isReg(paddr, timer_slave_pkg::OFF_CTRL2)   ? {24'h0, xorSel_q, 7'h0} :
    isReg(paddr, timer_slave_pkg::OFF_SLAVE)   ? {25'h0, slave_q.trigSel, 1'b0,
                                                  slave_q.slaveMode} :
    isReg(paddr, timer_slave_pkg::OFF_CAPMODE) ? {16'h0, capMode_q} :
    isReg(paddr, timer_slave_pkg::OFF_CAPEN)   ? capEnRd :
    isReg(paddr, timer_slave_pkg::OFF_COUNT)   ? {16'h0, cnt_q} :
    isReg(paddr, timer_slave_pkg::OFF_PRESC)   ? {16'h0, pscPre_q} :
    isReg(paddr, timer_slave_pkg::OFF_RELOAD)  ? {16'h0, arrPre_q} :
    isReg(paddr, timer_slave_pkg::OFF_FLAG)    ? {25'h0, flag_q} :
    isReg(paddr, timer_slave_pkg::OFF_INTCFG)  ? {25'h0, intCfg_q} :
    isReg(paddr, timer_slave_pkg::OFF_COMPARE) ? {16'h0, ccrPre_q} :
                                                 32'h0000_0000;

  // ****************************************
  // input resync and xor
  // ****************************************
  // the first stage feeds only the second; metastability stays inside
  logic [3:0] syncA_q, syncB_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          syncA_q[gi] <= 1'b0;
          syncB_q[gi] <= 1'b0;
        end else begin
          syncA_q[gi] <= channelPin[gi];
          syncB_q[gi] <= syncA_q[gi];
        end
      end
    end
  endgenerate

  wire xorIn = syncB_q[1] ^ syncB_q[2] ^ syncB_q[3];
  wire [1:0] rawIn = {syncB_q[1], xorSel_q ? xorIn : syncB_q[0]};

  // ****************************************
  // input filters and polarity
  // ****************************************
  // a new level must hold for one sample more than the programmed number
  wire [3:0] fltSet [2];
  assign fltSet[0] = capMode_q[timer_slave_pkg::CAP_FLT1_LO +: 4];
  assign fltSet[1] = capMode_q[timer_slave_pkg::CAP_FLT2_LO +: 4];
  logic [3:0] fltCnt_q [2];
  logic [1:0] fltOut_q;
  logic [1:0] filtIn;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filter
      always_ff @(posedge core_clk) begin
        if (rst) begin
          fltCnt_q[gi] <= 4'h0;
          fltOut_q[gi] <= 1'b0;
        end else if (rawIn[gi] == fltOut_q[gi]) begin
          fltCnt_q[gi] <= 4'h0;
        end else if (fltCnt_q[gi] >= fltSet[gi]) begin
          fltCnt_q[gi] <= 4'h0;
          fltOut_q[gi] <= rawIn[gi];
        end else begin
          fltCnt_q[gi] <= fltCnt_q[gi] + 4'h1;
        end
      end
      assign filtIn[gi] = (fltSet[gi] == 4'h0) ? rawIn[gi] : fltOut_q[gi];
    end
  endgenerate

  wire inOne = filtIn[0] ^ pol1_q;
  wire inTwo = filtIn[1] ^ pol2_q;

  // ****************************************
  // channel and trigger selection
  // ****************************************
  wire [1:0] sel1 = capMode_q[timer_slave_pkg::CAP_SEL1_LO +: 2];
  // select 00 leaves ch1 to the compare output; only then may software load the compare
  wire       cmpMode = (sel1 == 2'h0);
  wire       capOne = (sel1 == timer_slave_pkg::SEL_OWN) & inOne;
  wire trgi = (slave_q.trigSel == timer_slave_pkg::TS_INPUT_ONE) ? inOne :
              (slave_q.trigSel == timer_slave_pkg::TS_INPUT_TWO) ? inTwo : 1'b0;

  logic prevOne_q, prevTwo_q, prevTrg_q, prevCap_q;
  wire trgRise = trgi & ~prevTrg_q;
  wire trgFall = ~trgi & prevTrg_q;
  wire capRise = capOne & ~prevCap_q;

  // ****************************************
  // encoder decode
  // ****************************************
  wire [2:0] sms       = slave_q.slaveMode;
  wire encMode   = (sms == timer_slave_pkg::SMS_ENC2) |
                   (sms == timer_slave_pkg::SMS_ENC1) |
                   (sms == timer_slave_pkg::SMS_ENC12);
  wire rstMode   = (sms == timer_slave_pkg::SMS_RESET);
  wire gateMode  = (sms == timer_slave_pkg::SMS_GATED);
  wire edgeOne   = inOne ^ prevOne_q;
  wire edgeTwo   = inTwo ^ prevTwo_q;
  // both changing together is not a legal quadrature step: ignore it
  wire soloOne   = edgeOne & ~edgeTwo;
  wire soloTwo   = edgeTwo & ~edgeOne;
  wire encCount  = (soloOne & sms[1]) | (soloTwo & sms[0]);
  wire encDown   = soloOne ? (inOne ~^ inTwo) : (inOne ^ inTwo);
  wire dirUpdate = encMode & (soloOne | soloTwo);
  wire dirNow    = dirUpdate ? encDown : dir_q;

  // ****************************************
  // counting
  // ****************************************
  wire intTick = cen_q & (~gateMode | trgi);
  wire tick    = encMode ? (cen_q & encCount) : intTick;
  wire pscHit  = tick & (pscCnt_q == pscAct_q);
  wire atTop   = (cnt_q == arrAct_q);
  wire atZero  = (cnt_q == timer_slave_pkg::ZERO16);
  wire wrapEv  = pscHit & (dirNow ? atZero : atTop);
  wire [15:0] cntStep = dirNow ? (atZero ? arrAct_q : cnt_q - 16'h0001) :
                                 (atTop ? timer_slave_pkg::ZERO16 : cnt_q + 16'h0001);
  wire rstTrig = rstMode & trgRise;
  wire ugEv    = wrEvGen & pwdata[timer_slave_pkg::EVGEN_UG];
  wire update_event     = wrapEv | ugEv | (rstTrig & ~urs_q);
  wire trgFlag = rstTrig | (gateMode & cen_q & (trgRise | trgFall));

  wire [6:0] flagSet = {trgFlag, 4'h0, capRise & capEn1_q, update_event};
  wire [6:0] flagClr = wrFlag ? pwdata[6:0] & timer_slave_pkg::FLAG_MASK : 7'h00;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevOne_q <= 1'b0;
      prevTwo_q <= 1'b0;
      prevTrg_q <= 1'b0;
      prevCap_q <= 1'b0;
    end else begin
      prevOne_q <= inOne;
      prevTwo_q <= inTwo;
      prevTrg_q <= trgi;
      prevCap_q <= capOne;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cen_q     <= 1'b0;
      urs_q     <= 1'b0;
      xorSel_q  <= 1'b0;
      slave_q   <= '0;
      capMode_q <= 16'h0000;
      capEn1_q  <= 1'b0;
      pol1_q    <= 1'b0;
      pol2_q    <= 1'b0;
      pscPre_q  <= timer_slave_pkg::ZERO16;
      arrPre_q  <= timer_slave_pkg::RELOAD_RST;
      intCfg_q  <= 7'h00;
    end else begin
      if (wrCtrl1) begin
        cen_q <= pwdata[timer_slave_pkg::CTRL1_CEN];
        urs_q <= pwdata[timer_slave_pkg::CTRL1_URS];
      end
      if (wrCtrl2) xorSel_q <= pwdata[timer_slave_pkg::CTRL2_XOR];
      if (wrSlave) begin
        slave_q.slaveMode <= pwdata[timer_slave_pkg::SLAVE_SMS_LO +: 3];
        slave_q.trigSel   <= pwdata[timer_slave_pkg::SLAVE_TS_LO +: 3];
      end
      if (wrCapMd) capMode_q <= pwdata[15:0];
      if (wrCapEn) begin
        capEn1_q <= pwdata[timer_slave_pkg::CAPEN_E1];
        pol1_q   <= pwdata[timer_slave_pkg::CAPEN_P1];
        pol2_q   <= pwdata[timer_slave_pkg::CAPEN_P2];
      end
      if (wrPresc) pscPre_q <= pwdata[15:0];
      if (wrReld)  arrPre_q <= pwdata[15:0];
      if (wrIntCf) intCfg_q <= pwdata[6:0] & timer_slave_pkg::FLAG_MASK;
    end
  end

  // ****************************************
  // direction and count
  // ****************************************
  // direction is software owned outside encoder mode, hardware owned inside
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_q <= 1'b0;
    end else if (dirUpdate) begin
      dir_q <= encDown;
    end else if (wrCtrl1 & ~encMode) begin
      dir_q <= pwdata[timer_slave_pkg::CTRL1_DIR];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q    <= timer_slave_pkg::ZERO16;
      pscCnt_q <= timer_slave_pkg::ZERO16;
    end else if (rstTrig) begin
      cnt_q    <= timer_slave_pkg::ZERO16;
      pscCnt_q <= timer_slave_pkg::ZERO16;
    end else if (wrCount) begin
      cnt_q <= pwdata[15:0];
    end else if (ugEv) begin
      // the new reload goes live in this same cycle, so start from the buffered one
      cnt_q    <= dir_q ? arrPre_q : timer_slave_pkg::ZERO16;
      pscCnt_q <= timer_slave_pkg::ZERO16;
    end else if (tick) begin
      pscCnt_q <= pscHit ? timer_slave_pkg::ZERO16 : pscCnt_q + 16'h0001;
      if (pscHit) cnt_q <= cntStep;
    end
  end

  // ****************************************
  // buffered values
  // ****************************************
  // buffered values go live only on an update event; a capture loads the live compare value at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arrAct_q <= timer_slave_pkg::RELOAD_RST;
      pscAct_q <= timer_slave_pkg::ZERO16;
      ccrAct_q <= timer_slave_pkg::ZERO16;
      ccrPre_q <= timer_slave_pkg::ZERO16;
    end else begin
      if (capRise & capEn1_q) begin
        ccrPre_q <= cnt_q;
        ccrAct_q <= cnt_q;
      end else if (wrComp & cmpMode) begin
        ccrPre_q <= pwdata[15:0];
      end
      if (update_event) begin
        arrAct_q <= arrPre_q;
        pscAct_q <= pscPre_q;
        if (cmpMode) ccrAct_q <= ccrPre_q;
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // a flag event in the same cycle as its clear keeps the flag set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= 7'h00;
    end else begin
      flag_q <= (flag_q & ~flagClr) | flagSet;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      irq_q     <= 1'b0;
      cmpHit_q  <= 1'b0;
    end else begin
      pready_q  <= setupPh;
      pslverr_q <= setupPh & ~hitAny;
      if (setupPh) prdata_q <= rdMux;
      irq_q     <= |(flag_q & intCfg_q);
      cmpHit_q  <= cmpMode & (cnt_q == ccrAct_q);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign timerIrq   = irq_q;
  assign compareHit = cmpHit_q;

endmodule : timer_encoder_slave

/* File: shared/timer_slave_pkg.sv */
// constants and types for the encoder / slave-mode timer front end
// assumes a 32-bit apb master and a single core clock
//
// Contract
// - slave mode 001/010/011 selects encoder counting
// - each encoder input has polarity and filter
// - encoder counts valid edges while enabled
// - direction recomputed on every single input edge
// - counter wraps between 0 and reload value
// - capture, compare, prescaler keep working in encoder
// - input one edges: direction from input two
// - input two edges counted; uncounted inputs ignored (the code still updates dir_q on their edges)
// - xor select feeds ch1 filter from pins 2-4
// - xor signal serves trigger and capture alike
// - reset mode trigger clears counter and prescaler
// - reset trigger makes update event when source low
// - reset trigger restarts from 0, sets flag
// - trigger flag interrupts only when enabled
// - trigger inputs resynchronised before use
// - gated mode counts only while trigger active
// - gated mode never counts with enable low
// - gated mode flags both start and stop
// - trigger select 101 picks filtered ch1 input
// - input selection 01 maps own filtered input
// - polarity 0 plain, 1 inverted
// - filter 0000 passes sample straight through
package timer_slave_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL1   = 8'h00;
  localparam logic [7:0] OFF_CTRL2   = 8'h04;
  localparam logic [7:0] OFF_SLAVE   = 8'h08;
  localparam logic [7:0] OFF_CAPMODE = 8'h0C;
  localparam logic [7:0] OFF_CAPEN   = 8'h10;
  localparam logic [7:0] OFF_COUNT   = 8'h14;
  localparam logic [7:0] OFF_PRESC   = 8'h18;
  localparam logic [7:0] OFF_RELOAD  = 8'h1C;
  localparam logic [7:0] OFF_FLAG    = 8'h20;
  localparam logic [7:0] OFF_INTCFG  = 8'h24;
  localparam logic [7:0] OFF_EVGEN   = 8'h28;
  localparam logic [7:0] OFF_COMPARE = 8'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL1_CEN    = 0;
  localparam int CTRL1_URS    = 2;
  localparam int CTRL1_DIR    = 4;
  localparam int CTRL2_XOR    = 7;
  localparam int SLAVE_SMS_LO = 0;
  localparam int SLAVE_TS_LO  = 4;
  localparam int CAP_SEL1_LO  = 0;
  localparam int CAP_FLT1_LO  = 4;
  localparam int CAP_SEL2_LO  = 8;
  localparam int CAP_FLT2_LO  = 12;
  localparam int CAPEN_E1     = 0;
  localparam int CAPEN_P1     = 1;
  localparam int CAPEN_P2     = 5;
  localparam int FLAG_UPD     = 0;
  localparam int FLAG_CC1     = 1;
  localparam int FLAG_TRG     = 6;
  localparam int EVGEN_UG     = 0;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam int          CNT_W       = 16;
  localparam logic [15:0] RELOAD_RST  = 16'hFFFF;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [6:0]  FLAG_MASK   = 7'h43;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [2:0] {
    SMS_OFF   = 3'h0,
    SMS_ENC2  = 3'h1,
    SMS_ENC1  = 3'h2,
    SMS_ENC12 = 3'h3,
    SMS_RESET = 3'h4,
    SMS_GATED = 3'h5
  } slave_mode_t;

  localparam logic [2:0] TS_INPUT_ONE = 3'h5;
  localparam logic [2:0] TS_INPUT_TWO = 3'h6;
  localparam logic [1:0] SEL_OWN      = 2'h1;

  typedef struct packed {
    logic [2:0] trigSel;
    logic [2:0] slaveMode;
  } slave_cfg_t;

endpackage : timer_slave_pkg

/* File: test/encoder_model.sv */
// quadrature encoder on ch1 (bit0) and ch2 (bit1)
// assumes steps are called right after a core_clk edge
`timescale 1ns/1ps
module encoder_model (
  input  wire logic       core_clk,
  output logic      [1:0] quad
);
  // ****************************************
  // gray-coded position
  // ****************************************
  logic [1:0] phase_q = 2'h0;
  // one line moves per step, as a real encoder does
  assign quad = {phase_q[1], phase_q[1] ^ phase_q[0]};
  task automatic step(input logic fwd, input int gap);
    @(posedge core_clk);
    phase_q <= fwd ? phase_q + 2'h1 : phase_q - 2'h1;
    repeat (gap) @(posedge core_clk);
  endtask : step
  // both lines at once: only used to provoke the undefined case
  task automatic jam();
    @(posedge core_clk);
    phase_q <= phase_q + 2'h2;
  endtask : jam
endmodule : encoder_model

/* File: test/testbench.sv */
// self-checking bench for the encoder / slave-mode timer front end
// assumes zero-wait apb answers and three-edge pin latency
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // signals and tasks
  // ****************************************
  typedef struct packed {
    logic [2:0]  mode;
    logic        pol;
    logic [15:0] cnt;
    logic [31:0] ctl;
  } enc_row_t;
  logic        core_clk = 1'h0;
  logic        rst      = 1'h1;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  hiPins   = 2'h0;
  logic [31:0] prdata, rdData, hold;
  logic        pready, pslverr, timerIrq, rdErr, cmpHit;
  logic [1:0]  quad;
  int          errors = 0;
  int          samplesChecked = 0;
  enc_row_t    rows [5] = '{'{3'h1, 1'h0, 16'h2, 32'h01}, '{3'h2, 1'h0, 16'h2, 32'h01},
    '{3'h3, 1'h0, 16'h4, 32'h01}, '{3'h3, 1'h1, 16'h2, 32'h11}, '{3'h1, 1'h1, 16'h4, 32'h11}};
  initial forever #25 core_clk = ~core_clk;
  encoder_model enc_u (.core_clk(core_clk), .quad(quad));
  timer_encoder_slave dut_u (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channelPin({hiPins, quad}), .timerIrq(timerIrq), .compareHit(cmpHit));
  task automatic report_and_stop();
    if (errors == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      errors++;
      report_and_stop();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0);
    check(what, rdData, exp);
  endtask : rd
  // pin changes need three edges to reach the counter, so wait with margin
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask : settle
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    rd(timer_slave_pkg::OFF_RELOAD, 32'hFFFF, "reload_reset");
    rd(timer_slave_pkg::OFF_SLAVE, 32'h0, "slave_reset");
    wr(timer_slave_pkg::OFF_SLAVE, 32'hFFFFFFFF);
    rd(timer_slave_pkg::OFF_SLAVE, 32'h77, "slave_fields");
    apb(1'h1, 8'h30, 32'h1);
    check("unmapped_wr_err", {31'h0, rdErr}, 32'h1);
    rd(8'h30, 32'h0, "unmapped_rd");
    check("unmapped_rd_err", {31'h0, rdErr}, 32'h1);
    wr(timer_slave_pkg::OFF_RELOAD, 32'h5);
    wr(timer_slave_pkg::OFF_EVGEN, 32'h1);
    wr(timer_slave_pkg::OFF_CAPMODE, 32'h101);
    wr(timer_slave_pkg::OFF_CTRL1, 32'h1);
    foreach (rows[i]) begin
      wr(timer_slave_pkg::OFF_CAPEN, {30'h0, rows[i].pol, 1'h0});
      wr(timer_slave_pkg::OFF_SLAVE, {29'h0, rows[i].mode});
      settle();
      wr(timer_slave_pkg::OFF_COUNT, 32'h0);
      repeat (4) enc_u.step(1'h1, 3);
      settle();
      rd(timer_slave_pkg::OFF_COUNT, {16'h0, rows[i].cnt}, "enc_count");
      rd(timer_slave_pkg::OFF_CTRL1, rows[i].ctl, "enc_dir");
    end
    wr(timer_slave_pkg::OFF_CAPEN, 32'h0);
    wr(timer_slave_pkg::OFF_SLAVE, 32'h3);
    settle();
    wr(timer_slave_pkg::OFF_COUNT, 32'h4);
    repeat (3) enc_u.step(1'h1, 3);
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h1, "wrap_up");
    repeat (3) enc_u.step(1'h0, 3);
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h4, "wrap_down");
    enc_u.jam();
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h4, "jam_count");
    rd(timer_slave_pkg::OFF_CTRL1, 32'h11, "jam_dir");
    wr(timer_slave_pkg::OFF_CTRL1, 32'h0);
    repeat (2) enc_u.step(1'h1, 3);
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h4, "enc_disabled");
    // ch2 stays low from here on, so the xor trigger is ch3 ^ ch4
    hiPins <= {quad[1], 1'h0};
    wr(timer_slave_pkg::OFF_RELOAD, 32'hFFFF);
    wr(timer_slave_pkg::OFF_EVGEN, 32'h1);
    wr(timer_slave_pkg::OFF_CTRL2, 32'h80);
    wr(timer_slave_pkg::OFF_SLAVE, 32'h54);
    wr(timer_slave_pkg::OFF_CTRL1, 32'h1);
    settle();
    wr(timer_slave_pkg::OFF_FLAG, 32'hFFFFFFFF);
    wr(timer_slave_pkg::OFF_COUNT, 32'h1000);
    hiPins <= {quad[1], 1'h1};
    settle();
    apb(1'h0, timer_slave_pkg::OFF_COUNT, 32'h0);
    check("reset_restart", {31'h0, rdData < 32'h20}, 32'h1);
    rd(timer_slave_pkg::OFF_FLAG, 32'h41, "reset_flags");
    check("irq_masked", {31'h0, timerIrq}, 32'h0);
    wr(timer_slave_pkg::OFF_INTCFG, 32'h40);
    repeat (2) @(posedge core_clk);
    check("irq_enabled", {31'h0, timerIrq}, 32'h1);
    wr(timer_slave_pkg::OFF_INTCFG, 32'h0);
    // ch3 and ch4 high cancel in the xor, so the gate must stay shut
    hiPins <= 2'h3;
    wr(timer_slave_pkg::OFF_SLAVE, 32'h55);
    settle();
    wr(timer_slave_pkg::OFF_FLAG, 32'hFFFFFFFF);
    wr(timer_slave_pkg::OFF_COUNT, 32'h10);
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h10, "gate_closed");
    hiPins <= {quad[1], 1'h1};
    settle();
    rd(timer_slave_pkg::OFF_FLAG, 32'h40, "gate_start_flag");
    wr(timer_slave_pkg::OFF_FLAG, 32'hFFFFFFFF);
    hiPins <= {quad[1], 1'h0};
    settle();
    apb(1'h0, timer_slave_pkg::OFF_COUNT, 32'h0);
    hold = rdData;
    check("gate_counted", {31'h0, hold > 32'h10}, 32'h1);
    rd(timer_slave_pkg::OFF_FLAG, 32'h40, "gate_stop_flag");
    rd(timer_slave_pkg::OFF_COUNT, hold, "gate_stopped");
    wr(timer_slave_pkg::OFF_CTRL1, 32'h0);
    hiPins <= {quad[1], 1'h1};
    settle();
    rd(timer_slave_pkg::OFF_COUNT, hold, "gate_no_enable");
    // a second reset in mid-run must bring back the defaults
    rst    <= 1'h1;
    hiPins <= 2'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    rd(timer_slave_pkg::OFF_COUNT, 32'h0, "count_rerun");
    rd(timer_slave_pkg::OFF_FLAG, 32'h0, "flag_rerun");
    check("irq_rerun", {31'h0, timerIrq}, 32'h0);
    wr(timer_slave_pkg::OFF_COMPARE, 32'h3);
    wr(timer_slave_pkg::OFF_EVGEN, 32'h1);
    repeat (2) @(posedge core_clk);
    check("cmp_miss", {31'h0, cmpHit}, 32'h0);
    wr(timer_slave_pkg::OFF_COUNT, 32'h3);
    repeat (2) @(posedge core_clk);
    check("cmp_hit", {31'h0, cmpHit}, 32'h1);
    // a two-sample glitch must not pass a four-sample filter
    wr(timer_slave_pkg::OFF_CAPMODE, 32'h30);
    wr(timer_slave_pkg::OFF_CTRL2, 32'h80);
    wr(timer_slave_pkg::OFF_SLAVE, 32'h55);
    wr(timer_slave_pkg::OFF_CTRL1, 32'h1);
    hiPins <= 2'h1;
    repeat (2) @(posedge core_clk);
    hiPins <= 2'h0;
    settle();
    rd(timer_slave_pkg::OFF_COUNT, 32'h3, "filter_glitch");
    hiPins <= 2'h1;
    settle();
    apb(1'h0, timer_slave_pkg::OFF_COUNT, 32'h0);
    check("filter_pass", {31'h0, rdData > 32'h3}, 32'h1);
    report_and_stop();
  end
endmodule : testbench

/* File: test/timer_slave_checker.sv */
// concurrent checks on the apb and interrupt ports of the timer front end
// assumes zero-wait apb answers and a registered interrupt level
`timescale 1ns/1ps
module timer_slave_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timerIrq
);
  // ****************************************
  // bus and interrupt properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence readDone(logic [7:0] a);
    pready && psel && penable && !pwrite && paddr == a;
  endsequence
  // interrupt mask cleared: irq must drop before the next write can land
  sequence maskOff;
    pready && pwrite && paddr == timer_slave_pkg::OFF_INTCFG && pwdata == 32'h0;
  endsequence
  ready_after_setup_a: assert property (setupPh |=> pready)
    else $error("ready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  error_needs_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  error_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  flag_bits_a: assert property (readDone(timer_slave_pkg::OFF_FLAG) |->
    (prdata & ~32'h43) == 32'h0) else $error("flag spare bits set");
  slave_bits_a: assert property (readDone(timer_slave_pkg::OFF_SLAVE) |->
    (prdata & ~32'h77) == 32'h0) else $error("mode spare bits set");
  irq_masked_a: assert property (maskOff |=> ##1 !timerIrq [*2])
    else $error("irq while masked");
endmodule : timer_slave_checker

bind timer_encoder_slave timer_slave_checker chk_u (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timerIrq(timerIrq)
);
